// [design/deep_sync_fifo.sv]
// Purpose: 18-bit deep synchronous FIFO with flags
// Assumes: Write and read ports share clk
// Notes: Depth from ADDR_W: 13, 15 or 16
//
// Overview of operation
// [R1] 18-bit input and output, own enables
// [R2] Depth 8K, 32K or 64K words
// [R3] Write enable stores input on edge
// [R4] One write every cycle while enabled
// [R5] Read enable delivers next queued word
// [R6] Concurrent read and write allowed
// [R7] Ports may share one clock
// [R8] Caller supplies free-running clocks
// [R9] Empty, full, half, almost flags
// [R10] Retransmit and synchronous almost flags
// [R11] Cascade outputs feed next device; tied low here
// [R12] Last device closes cascade ring; no ring logic here
// [R13] First-in-chain strap low on first; strap unused here
// [R14] Write ignored while full
// [R15] Read ignored while empty
// [R16] Empty and full flags are clocked
// [R17] Load low accesses offset register
// [R18] Output enable off tri-states outputs; here only dataOutEn drops, dataOut stays driven
// [R19] Half full above half depth
`timescale 1ns/100ps
module deep_sync_fifo #(
    parameter int ADDR_W = fifo_pkg::ADDR_W_DEF
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [17:0] dataIn,
    input wire logic writeEn_n,
    input wire logic readEn_n,
    input wire logic outputEn_n,
    input wire logic offset_load_n,
    input wire logic retransmit_strobe,
    input wire logic first_in_chain,
    input wire logic write_chain_in,
    input wire logic read_chain_in,
    output logic [17:0] dataOut,
    output logic dataOutEn,
    output logic empty_flag_n,
    output logic full_flag_n,
    output logic half_full_flag,
    output logic almost_empty_flag,
    output logic almost_full_flag,
    output logic write_chain_out,
    output logic read_chain_out,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    output logic irq
);
    // Word count at the configured depth
    localparam int DEPTH = 1 << ADDR_W;

    // ==========================================
    // Storage and pointers
    // ==========================================
    // [R2] Depth array
    logic [17:0] mem [DEPTH];
    logic [ADDR_W-1:0] wrPtr_r, wrPtr_nxt;
    logic [ADDR_W-1:0] rdPtr_r, rdPtr_nxt;
    logic [ADDR_W-1:0] rtMark_r, rtMark_nxt;
    logic [ADDR_W:0] count_r, count_nxt;
    logic [17:0] dataOut_r, dataOut_nxt;
    logic [17:0] aeOff_r, aeOff_nxt;
    logic [17:0] afOff_r, afOff_nxt;
    logic offSel_r, offSel_nxt;
    logic rdSel_r, rdSel_nxt;
    logic doWrite, doRead, doRt, overrun;
    logic [31:0] regRdata_r, regRdata_nxt;
    logic [fifo_pkg::IRQ_W-1:0] irqEvents, irqStatus, irqEnable;

    fifo_flag_if #(.AW(ADDR_W)) flagBus ();

    // ==========================================
    // Request decode
    // ==========================================
    always_comb begin
        // [R14] Write gated by full
        doWrite = !writeEn_n && offset_load_n && (count_r != (ADDR_W+1)'(DEPTH));
        // [R15] Read gated by empty
        doRead = !readEn_n && offset_load_n && (count_r != '0);
        // [R10] Retransmit rewinds read
        doRt = retransmit_strobe && offset_load_n;
        // Refused write, reported as overrun
        overrun = !writeEn_n && offset_load_n && (count_r == (ADDR_W+1)'(DEPTH));
    end

    // ==========================================
    // Pointers
    // ==========================================
    always_comb begin
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        // Mark stays at address zero
        rtMark_nxt = rtMark_r;
        // Pointers wrap naturally at the depth
        // [R3] Store on write
        if (doWrite) begin
            wrPtr_nxt = wrPtr_r + 1'b1;
        end
        if (doRt) begin
            rdPtr_nxt = rtMark_r;
        end else if (doRead) begin
            rdPtr_nxt = rdPtr_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            rtMark_r <= '0;
        end else begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            rtMark_r <= rtMark_nxt;
        end
    end

    // Storage has no reset; only written words are read
    always_ff @(posedge clk) begin
        // [R4] Back-to-back writes
        if (doWrite) begin
            mem[wrPtr_r] <= dataIn;
        end
    end

    // ==========================================
    // Occupancy count
    // ==========================================
    always_comb begin
        count_nxt = count_r;
        if (doRt) begin
            // Replay from the mark, this cycle's write included
            count_nxt = (ADDR_W+1)'(wrPtr_nxt - rtMark_r);
            if (wrPtr_nxt == rtMark_r && (count_r != '0 || doWrite)) begin
                count_nxt = (ADDR_W+1)'(DEPTH);
            end
        end else begin
            // [R6] Concurrent update
            // Read and write in one cycle cancel
            unique case ({doWrite, doRead})
                2'b10: count_nxt = count_r + 1'b1;
                2'b01: count_nxt = count_r - 1'b1;
                default: count_nxt = count_r;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    // ==========================================
    // Output word
    // ==========================================
    always_comb begin
        // Holds its word until the next read
        dataOut_nxt = dataOut_r;
        // [R5] Deliver next word
        // Retransmit has priority over a read
        if (doRead && !doRt) begin
            dataOut_nxt = mem[rdPtr_r];
        end
        // [R17] Offset register read
        if (!offset_load_n && !readEn_n) begin
            dataOut_nxt = rdSel_r ? afOff_r : aeOff_r;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dataOut_r <= 18'h00000;
        end else begin
            dataOut_r <= dataOut_nxt;
        end
    end

    // ==========================================
    // Flag offset registers
    // ==========================================
    always_comb begin
        aeOff_nxt = aeOff_r;
        afOff_nxt = afOff_r;
        // Offset selectors restart whenever load is released
        offSel_nxt = 1'b0;
        rdSel_nxt = 1'b0;
        // [R17] Offset register access
        if (!offset_load_n) begin
            offSel_nxt = offSel_r;
            rdSel_nxt = rdSel_r;
            // Alternates: almost-empty first, then almost-full
            if (!writeEn_n) begin
                if (offSel_r) begin
                    afOff_nxt = dataIn;
                end else begin
                    aeOff_nxt = dataIn;
                end
                offSel_nxt = !offSel_r;
            end
            if (!readEn_n) begin
                rdSel_nxt = !rdSel_r;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aeOff_r <= fifo_pkg::AE_OFFSET_RST;
            afOff_r <= fifo_pkg::AF_OFFSET_RST;
            offSel_r <= 1'b0;
            rdSel_r <= 1'b0;
        end else begin
            aeOff_r <= aeOff_nxt;
            afOff_r <= afOff_nxt;
            offSel_r <= offSel_nxt;
            rdSel_r <= rdSel_nxt;
        end
    end

    // ==========================================
    // Flags
    // ==========================================
    assign flagBus.count = count_r;
    assign flagBus.aeOffset = aeOff_r;
    assign flagBus.afOffset = afOff_r;

    fifo_flag_unit #(.AW(ADDR_W)) flagUnit (
        .clk(clk),
        .reset_n(reset_n),
        .flags(flagBus)
    );

    // [R16] Clocked empty and full
    assign empty_flag_n = flagBus.emptyN;
    assign full_flag_n = flagBus.fullN;
    // [R9] Almost flags, active low
    assign almost_empty_flag = flagBus.almostEmptyN;
    assign almost_full_flag = flagBus.almostFullN;
    // [R19] Half full threshold
    assign half_full_flag = flagBus.halfFull;

    // ==========================================
    // Output and cascade
    // ==========================================
    // [R1] 18-bit registered output
    assign dataOut = dataOut_r;
    // [R18] Enable low raises dataOutEn; dataOut is driven either way
    assign dataOutEn = !outputEn_n;
    // Standalone build: chain outputs idle, inputs unused
    assign write_chain_out = 1'b0;
    assign read_chain_out = 1'b0;

    // ==========================================
    // Register port and interrupt
    // ==========================================
    assign irqEvents = {overrun, !flagBus.almostFullN, !flagBus.almostEmptyN,
        flagBus.halfFull, !flagBus.fullN, !flagBus.emptyN};

    fifo_irq_unit #(.W(fifo_pkg::IRQ_W)) irqUnit (
        .clk(clk),
        .reset_n(reset_n),
        .events(irqEvents),
        .clearBits(regWdata[fifo_pkg::IRQ_W-1:0]),
        .clearWr(regWr && regAddr == fifo_pkg::REG_CLEAR),
        .enableIn(regWdata[fifo_pkg::IRQ_W-1:0]),
        .enableWr(regWr && regAddr == fifo_pkg::REG_ENABLE),
        .status(irqStatus),
        .enable(irqEnable),
        .irq(irq)
    );

    always_comb begin
        regRdata_nxt = 32'h00000000;
        if (regRd) begin
            unique case (regAddr)
                fifo_pkg::REG_STATUS: regRdata_nxt = 32'(irqStatus);
                fifo_pkg::REG_ENABLE: regRdata_nxt = 32'(irqEnable);
                fifo_pkg::REG_COUNT: regRdata_nxt = 32'(count_r);
                default: regRdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdata_r <= 32'h00000000;
        end else begin
            regRdata_r <= regRdata_nxt;
        end
    end

    assign regRdata = regRdata_r;
endmodule

// [design/fifo_pkg.sv]
// Purpose: Shared constants for the deep synchronous FIFO
// Assumes: One clock domain at 20 MHz
// Notes: Depth selected by address width parameter
package fifo_pkg;
    localparam int DATA_W = 18;
    localparam int ADDR_W_8K = 13;
    localparam int ADDR_W_32K = 15;
    localparam int ADDR_W_64K = 16;
    localparam int ADDR_W_DEF = ADDR_W_8K;
    // Default offsets for almost flags
    localparam logic [17:0] AE_OFFSET_RST = 18'h00007;
    localparam logic [17:0] AF_OFFSET_RST = 18'h00007;
    // Interrupt status bit positions
    localparam int IRQ_EMPTY = 0;
    localparam int IRQ_FULL = 1;
    localparam int IRQ_HALF = 2;
    localparam int IRQ_AEMPTY = 3;
    localparam int IRQ_AFULL = 4;
    localparam int IRQ_OVERRUN = 5;
    localparam int IRQ_W = 6;
    // Register port offsets
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CLEAR = 4'h1;
    localparam logic [3:0] REG_ENABLE = 4'h2;
    localparam logic [3:0] REG_COUNT = 4'h3;
endpackage

// [design/fifo_flag_if.sv]
// Purpose: Carries occupancy flags from the flag unit
// Assumes: Single clock
// Notes: Driven by fifo_flag_unit
`timescale 1ns/100ps
interface fifo_flag_if #(parameter int AW = 13);
    logic [AW:0] count;
    logic [17:0] aeOffset;
    logic [17:0] afOffset;
    logic emptyN;
    logic fullN;
    logic halfFull;
    logic almostEmptyN;
    logic almostFullN;
    modport unit (input count, input aeOffset, input afOffset,
        output emptyN, output fullN, output halfFull, output almostEmptyN, output almostFullN);
    modport user (output count, output aeOffset, output afOffset,
        input emptyN, input fullN, input halfFull, input almostEmptyN, input almostFullN);
endinterface

// [design/fifo_flag_unit.sv]
// Purpose: Registered occupancy flags
// Assumes: Count already updated each cycle
// Notes: Flags follow count one cycle later
`timescale 1ns/100ps
module fifo_flag_unit #(
    parameter int AW = 13
) (
    input wire logic clk,
    input wire logic reset_n,
    fifo_flag_if.unit flags
);
    localparam logic [AW:0] DEPTH = (AW+1)'(1) << AW;
    localparam logic [AW:0] HALF = DEPTH >> 1;

    logic [4:0] flags_r;
    logic [4:0] flags_nxt;
    logic [AW:0] aeLim;
    logic [AW:0] afLim;

    always_comb begin
        aeLim = (AW+1)'(flags.aeOffset);
        afLim = DEPTH - (AW+1)'(flags.afOffset);
        flags_nxt[0] = (flags.count != '0);
        flags_nxt[1] = (flags.count != DEPTH);
        flags_nxt[2] = (flags.count > HALF);
        flags_nxt[3] = (flags.count > aeLim);
        flags_nxt[4] = (flags.count < afLim);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_r <= 5'h12;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign flags.emptyN = flags_r[0];
    assign flags.fullN = flags_r[1];
    assign flags.halfFull = flags_r[2];
    assign flags.almostEmptyN = flags_r[3];
    assign flags.almostFullN = flags_r[4];
endmodule

// [design/fifo_irq_unit.sv]
// Purpose: Sticky event status, enable and interrupt
// Assumes: Events are one-cycle pulses or levels
// Notes: Set wins over clear
`timescale 1ns/100ps
module fifo_irq_unit #(
    parameter int W = 6
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [W-1:0] events,
    input wire logic [W-1:0] clearBits,
    input wire logic clearWr,
    input wire logic [W-1:0] enableIn,
    input wire logic enableWr,
    output logic [W-1:0] status,
    output logic [W-1:0] enable,
    output logic irq
);
    logic [W-1:0] status_r;
    logic [W-1:0] status_nxt;
    logic [W-1:0] enable_r;
    logic [W-1:0] enable_nxt;

    always_comb begin
        status_nxt = status_r;
        if (clearWr) begin
            status_nxt = status_nxt & ~clearBits;
        end
        status_nxt = status_nxt | events;
        enable_nxt = enableWr ? enableIn : enable_r;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_r <= '0;
            enable_r <= '0;
        end else begin
            status_r <= status_nxt;
            enable_r <= enable_nxt;
        end
    end

    assign status = status_r;
    assign enable = enable_r;
    assign irq = |(status_r & enable_r);
endmodule

// [sim/fifo_producer_model.sv]
// Purpose: Producer driving the write port in bursts
// Assumes: Shares clk with the FIFO
// Notes: Idle data toggles so stale words never look valid
`timescale 1ns/100ps
module fifo_producer_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [17:0] base,
    input wire logic [7:0] len,
    output logic [17:0] dataIn,
    output logic writeEn_n
);
    logic [7:0] left;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            left <= 8'h00;
            dataIn <= 18'h00000;
            writeEn_n <= 1'b1;
        end else if (start) begin
            left <= len;
            dataIn <= base;
            writeEn_n <= 1'b0;
        end else if (left > 8'h01) begin
            left <= left - 8'h01;
            dataIn <= dataIn + 18'h00001;
        end else begin
            left <= 8'h00;
            dataIn <= ~dataIn;
            writeEn_n <= 1'b1;
        end
    end
endmodule

// [sim/deep_sync_fifo_monitor.sv]
// Purpose: Port-level checks for deep_sync_fifo
// Assumes: One clock, async active-low reset
// Notes: Flags lag a write by two edges
`timescale 1ns/100ps
module deep_sync_fifo_monitor (
    input logic clk,
    input logic reset_n,
    input logic writeEn_n,
    input logic readEn_n,
    input logic outputEn_n,
    input logic offset_load_n,
    input logic retransmit_strobe,
    input logic [17:0] dataOut,
    input logic dataOutEn,
    input logic empty_flag_n,
    input logic full_flag_n,
    input logic almost_full_flag,
    input logic [3:0] regAddr,
    input logic [31:0] regWdata,
    input logic regWr,
    input logic regRd,
    input logic [31:0] regRdata,
    input logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    oe_follow_a: assert property (dataOutEn == !outputEn_n) else $error("output enable mismatch");
    read_hold_a: assert property (readEn_n && !retransmit_strobe |=> $stable(dataOut))
        else $error("output moved without read");
    write_fill_a: assert property (!writeEn_n && offset_load_n && readEn_n && !retransmit_strobe
        |=> ##1 empty_flag_n) else $error("empty flag stuck after write");
    empty_hold_a: assert property (!empty_flag_n && writeEn_n && $past(writeEn_n) && !retransmit_strobe
        && !$past(retransmit_strobe) |=> !empty_flag_n) else $error("empty flag dropped");
    full_hold_a: assert property (!full_flag_n && readEn_n && $past(readEn_n) && !retransmit_strobe
        && !$past(retransmit_strobe) |=> !full_flag_n) else $error("full flag dropped");
    af_full_a: assert property (!full_flag_n |-> !almost_full_flag) else $error("almost full off while full");
    reg_idle_a: assert property (!regRd |=> regRdata == 32'h00000000) else $error("read data without read");
    irq_off_a: assert property (regWr && regAddr == fifo_pkg::REG_ENABLE && regWdata[5:0] == 6'h00 ##1 !regWr
        |=> !irq) else $error("irq with all enables off");
endmodule
bind deep_sync_fifo deep_sync_fifo_monitor mon (.clk(clk), .reset_n(reset_n), .writeEn_n(writeEn_n),
    .readEn_n(readEn_n), .outputEn_n(outputEn_n), .offset_load_n(offset_load_n),
    .retransmit_strobe(retransmit_strobe), .dataOut(dataOut), .dataOutEn(dataOutEn), .empty_flag_n(empty_flag_n),
    .full_flag_n(full_flag_n), .almost_full_flag(almost_full_flag), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));

// [sim/test_deep_sync_fifo.sv]
// Purpose: Self-checking bench for deep_sync_fifo
// Assumes: Depth shrunk to 16 words
// Notes: Tasks start after a rising edge
`timescale 1ns/100ps
module test_deep_sync_fifo;
    localparam int AW = 4;
    localparam int DEPTH = 1 << AW;
    logic clk, reset_n, writeEn_n, readEn_n, outputEn_n, offset_load_n, retransmit_strobe, start;
    logic [17:0] dataIn, base, dataOut;
    logic [7:0] len;
    logic dataOutEn, empty_flag_n, full_flag_n, half_full_flag, almost_empty_flag, almost_full_flag, irq;
    logic [3:0] regAddr;
    logic [31:0] regWdata, regRdata, rd;
    logic regWr, regRd;
    int failures = 0;
    int tests_run = 0;
    deep_sync_fifo #(.ADDR_W(AW)) uut (.clk(clk), .reset_n(reset_n), .dataIn(dataIn), .writeEn_n(writeEn_n),
        .readEn_n(readEn_n), .outputEn_n(outputEn_n), .offset_load_n(offset_load_n),
        .retransmit_strobe(retransmit_strobe), .first_in_chain(1'b0), .write_chain_in(1'b0),
        .read_chain_in(1'b0), .dataOut(dataOut), .dataOutEn(dataOutEn), .empty_flag_n(empty_flag_n),
        .full_flag_n(full_flag_n), .half_full_flag(half_full_flag), .almost_empty_flag(almost_empty_flag),
        .almost_full_flag(almost_full_flag), .write_chain_out(), .read_chain_out(), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));
    fifo_producer_model prod (.clk(clk), .reset_n(reset_n), .start(start), .base(base), .len(len),
        .dataIn(dataIn), .writeEn_n(writeEn_n));
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic regAccess(input logic wr, input logic [3:0] addr, input logic [31:0] wdata);
        @(posedge clk);
        regAddr <= addr;
        regWdata <= wdata;
        regWr <= wr;
        regRd <= !wr;
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
        // Read data stand only in the cycle after the strobe
        @(negedge clk);
        rd = (wr) ? 32'h00000000 : regRdata;
    endtask
    task automatic produce(input logic [17:0] b, input logic [7:0] n);
        @(posedge clk);
        base <= b;
        len <= n;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (n) @(posedge clk);
        repeat (2) @(negedge clk);
    endtask
    task automatic pull(input logic [17:0] b, input int n);
        @(posedge clk);
        readEn_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            if (i == n - 1) readEn_n <= 1'b1;
            @(negedge clk);
            check("dataOut", 32'(b + 18'(i)), 32'(dataOut));
        end
        repeat (2) @(negedge clk);
    endtask
    task automatic t_stream();
        produce(18'h3a5c0, 8'h05);
        check("empty_flag_n", 1, empty_flag_n);
        pull(18'h3a5c0, 5);
        check("empty_flag_n", 0, empty_flag_n);
        @(posedge clk);
        readEn_n <= 1'b0;
        @(posedge clk);
        readEn_n <= 1'b1;
        @(negedge clk);
        check("dataOut", 32'h0003a5c4, 32'(dataOut));
        $display("stream test done");
    endtask
    task automatic t_fill();
        produce(18'h00100, 8'(DEPTH + 1));
        check("full_flag_n", 0, full_flag_n);
        check("half_full_flag", 1, half_full_flag);
        check("almost_full_flag", 0, almost_full_flag);
        check("almost_empty_flag", 1, almost_empty_flag);
        regAccess(1'b0, fifo_pkg::REG_COUNT, 32'h0);
        check("count", 32'(DEPTH), rd);
        regAccess(1'b0, fifo_pkg::REG_STATUS, 32'h0);
        check("overrun", 1, rd[fifo_pkg::IRQ_OVERRUN]);
        regAccess(1'b1, fifo_pkg::REG_ENABLE, 32'h00000020);
        check("irq", 1, irq);
        regAccess(1'b1, fifo_pkg::REG_CLEAR, 32'h00000020);
        check("irq", 0, irq);
        regAccess(1'b1, fifo_pkg::REG_ENABLE, 32'h00000000);
        regAccess(1'b0, 4'hc, 32'h0);
        check("unmapped", 0, rd);
        pull(18'h00100, DEPTH);
        check("half_full_flag", 0, half_full_flag);
        check("full_flag_n", 1, full_flag_n);
        $display("fill test done");
    endtask
    task automatic t_misc();
        @(posedge clk);
        outputEn_n <= 1'b1;
        @(negedge clk);
        check("dataOutEn", 0, dataOutEn);
        check("dataOut", 32'h0000010f, 32'(dataOut));
        @(posedge clk);
        outputEn_n <= 1'b0;
        offset_load_n <= 1'b0;
        produce(18'h00003, 8'h01);
        check("dataOutEn", 1, dataOutEn);
        produce(18'h00004, 8'h01);
        pull(18'h00003, 2);
        @(posedge clk);
        offset_load_n <= 1'b1;
        produce(18'h2a000, 8'h03);
        check("almost_empty_flag", 0, almost_empty_flag);
        produce(18'h2a003, 8'h01);
        check("almost_empty_flag", 1, almost_empty_flag);
        pull(18'h2a000, 4);
        $display("output and offset test done");
    endtask
    task automatic t_retx();
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        check("almost_empty_flag", 0, almost_empty_flag);
        check("empty_flag_n", 0, empty_flag_n);
        produce(18'h15a50, 8'h03);
        pull(18'h15a50, 2);
        @(posedge clk);
        retransmit_strobe <= 1'b1;
        @(posedge clk);
        retransmit_strobe <= 1'b0;
        pull(18'h15a50, 3);
        check("empty_flag_n", 0, empty_flag_n);
        $display("reset and retransmit test done");
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #(50 * 3000);
        failures++;
        conclude();
    end
    initial begin
        reset_n = 1'b0;
        readEn_n = 1'b1;
        outputEn_n = 1'b0;
        offset_load_n = 1'b1;
        retransmit_strobe = 1'b0;
        start = 1'b0;
        base = 18'h00000;
        len = 8'h00;
        regAddr = 4'h0;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        check("full_flag_n", 1, full_flag_n);
        check("irq", 0, irq);
        check("almost_empty_flag", 0, almost_empty_flag);
        t_stream();
        t_fill();
        t_misc();
        t_retx();
        conclude();
    end
endmodule
